// ===== design/mcor_regs.sv
// Modem control output registers with half-duplex interlock and APB access
//
// The APB interface to the registers and the register offsets were decided locally.
module mcor_regs (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Firmware mode command for half-duplex
   input  wire logic        FW_HDX_WE,
   input  wire logic        FW_HDX_VAL,
   // Line unit state
   input  wire logic        TX_DATA_PENDING,
   input  wire logic        TX_ACTIVE,
   input  wire logic        RX_ACTIVE,
   input  wire logic        DIFF_SWITCH,
   // Modem inputs
   input  wire logic        CARRIER_DETECT,
   input  wire logic        MODEM_READY,
   // Modem control outputs
   output logic             RATE_SELECT,
   output logic             STANDBY_SELECT,
   output logic             REMOTE_LOOP_REQ,
   output logic             LOCAL_LOOP_REQ,
   output logic             BAND_SELECT,
   output logic             TERMINAL_READY,
   output logic             POLLING,
   output logic             REQ_TO_SEND,
   // Line unit steering
   output logic             TX_LOAD_EN,
   output logic             RX_ENABLE,
   output logic [1:0]       IFACE_TYPE
);

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  ifsel;
      logic [7:0]  rate;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        rts;
      logic        tx_load;
      logic        rx_en;
      logic [1:0]  iface;
   } mcor_state_t;

   mcor_state_t st_reg;
   mcor_state_t st_next;

   logic       access;
   logic       wr_hit;
   logic       mapped;
   logic       hdx;
   logic [7:0] wmask;
   logic [7:0] wdata;

   assign access = PSEL & PENABLE & ~st_reg.ready;
   assign hdx    = st_reg.ctrl[mcor_pkg::MCOR_CTRL_HDX];
   assign wdata  = PWDATA[7:0];
   assign wmask  = PSTRB[0] ? 8'hFF : 8'h00;

   always_comb begin
      st_next       = st_reg;
      st_next.ready = 1'b0;
      // Error flag lives one cycle, with ready, so the pin is a plain flop
      st_next.slverr = 1'b0;
      mapped        = 1'b1;
      wr_hit        = access & PWRITE;
      if (access) begin
         st_next.ready  = 1'b1;
         st_next.rdata  = 32'h0000_0000;
         case (PADDR)
            mcor_pkg::MCOR_ADDR_CTRL: begin
               st_next.rdata[7:0] = st_reg.ctrl;
               if (wr_hit) begin
                  st_next.ctrl = (st_reg.ctrl & ~(mcor_pkg::MCOR_CTRL_WMASK & wmask))
                               | (wdata & mcor_pkg::MCOR_CTRL_WMASK & wmask);
               end
            end
            mcor_pkg::MCOR_ADDR_IFSEL: begin
               st_next.rdata[7:0] = st_reg.ifsel;
               if (wr_hit) begin
                  st_next.ifsel = (st_reg.ifsel & ~(mcor_pkg::MCOR_IFSEL_WMASK & wmask))
                                | (wdata & mcor_pkg::MCOR_IFSEL_WMASK & wmask);
               end
            end
            mcor_pkg::MCOR_ADDR_RATE: begin
               st_next.rdata[7:0] = st_reg.rate;
               if (wr_hit) begin
                  st_next.rate = (st_reg.rate & ~(mcor_pkg::MCOR_RATE_WMASK & wmask))
                               | (wdata & mcor_pkg::MCOR_RATE_WMASK & wmask);
               end
            end
            mcor_pkg::MCOR_ADDR_STAT: begin
               st_next.rdata[0] = st_reg.rts;
               st_next.rdata[1] = st_reg.tx_load;
               st_next.rdata[2] = st_reg.rx_en;
               st_next.rdata[5:4] = st_reg.iface;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
         st_next.slverr = ~mapped;
      end
      if (FW_HDX_WE) begin
         st_next.ctrl[mcor_pkg::MCOR_CTRL_HDX] = FW_HDX_VAL;
      end
      st_next.tx_load = TX_DATA_PENDING & ~(hdx & (RX_ACTIVE | CARRIER_DETECT));
      st_next.rts = st_next.tx_load & MODEM_READY;
      st_next.rx_en = ~(hdx & TX_ACTIVE);
      st_next.iface = mcor_pkg::MCOR_IF_SINGLE_ENDED;
      if (st_reg.ifsel[mcor_pkg::MCOR_IF_ENABLE]) begin
         if (st_reg.ifsel[mcor_pkg::MCOR_IF_INTEGRAL]) begin
            st_next.iface = mcor_pkg::MCOR_IF_INTEGRAL_TYPE;
         end else if (st_reg.ifsel[mcor_pkg::MCOR_IF_V35]) begin
            st_next.iface = mcor_pkg::MCOR_IF_V35_TYPE;
         end else if (st_reg.ifsel[mcor_pkg::MCOR_IF_DIFF] & DIFF_SWITCH) begin
            st_next.iface = mcor_pkg::MCOR_IF_DIFF_TYPE;
         end else begin
            st_next.iface = mcor_pkg::MCOR_IF_SINGLE_ENDED;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_reg.ctrl    <= mcor_pkg::MCOR_CTRL_RST;
         st_reg.ifsel   <= mcor_pkg::MCOR_IFSEL_RST;
         st_reg.rate    <= mcor_pkg::MCOR_RATE_RST;
         st_reg.rdata   <= 32'h0000_0000;
         st_reg.ready   <= 1'b0;
         st_reg.slverr  <= 1'b0;
         st_reg.rts     <= 1'b0;
         st_reg.tx_load <= 1'b0;
         st_reg.rx_en   <= 1'b1;
         st_reg.iface   <= mcor_pkg::MCOR_IF_SINGLE_ENDED;
      end else begin
         st_reg <= st_next;
      end
   end

   assign PRDATA  = st_reg.rdata;
   assign PREADY  = st_reg.ready;
   assign PSLVERR = st_reg.slverr;
   assign RATE_SELECT     = st_reg.rate[mcor_pkg::MCOR_RATE_HIGH];
   assign STANDBY_SELECT  = st_reg.ctrl[mcor_pkg::MCOR_CTRL_STANDBY];
   assign REMOTE_LOOP_REQ = st_reg.ctrl[mcor_pkg::MCOR_CTRL_RLOOP];
   assign LOCAL_LOOP_REQ  = st_reg.ctrl[mcor_pkg::MCOR_CTRL_LLOOP];
   assign BAND_SELECT     = st_reg.ctrl[mcor_pkg::MCOR_CTRL_BAND];
   assign TERMINAL_READY  = st_reg.ctrl[mcor_pkg::MCOR_CTRL_DTR];
   assign POLLING         = st_reg.ctrl[mcor_pkg::MCOR_CTRL_POLL];
   assign REQ_TO_SEND     = st_reg.rts;
   assign TX_LOAD_EN      = st_reg.tx_load;
   assign RX_ENABLE       = st_reg.rx_en;
   assign IFACE_TYPE      = st_reg.iface;

endmodule : mcor_regs

// ===== inc/mcor_pkg.sv
// Package: register map and field positions of the modem control output block
package mcor_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] MCOR_ADDR_CTRL  = 12'h000;
   localparam logic [11:0] MCOR_ADDR_IFSEL = 12'h004;
   localparam logic [11:0] MCOR_ADDR_RATE  = 12'h008;
   localparam logic [11:0] MCOR_ADDR_STAT  = 12'h00C;
   // Control register fields
   localparam int MCOR_CTRL_STANDBY  = 1;
   localparam int MCOR_CTRL_RLOOP    = 2;
   localparam int MCOR_CTRL_LLOOP    = 3;
   localparam int MCOR_CTRL_HDX      = 4;
   localparam int MCOR_CTRL_BAND     = 5;
   localparam int MCOR_CTRL_DTR      = 6;
   localparam int MCOR_CTRL_POLL     = 7;
   // Interface select fields
   localparam int MCOR_IF_ENABLE     = 0;
   localparam int MCOR_IF_CRC32_EN   = 2;
   localparam int MCOR_IF_INTEGRAL   = 3;
   localparam int MCOR_IF_V35        = 4;
   localparam int MCOR_IF_CRC32_MT   = 5;
   localparam int MCOR_IF_SINGLE     = 6;
   localparam int MCOR_IF_DIFF       = 7;
   // Rate register field
   localparam int MCOR_RATE_HIGH     = 7;
   // Software-writable masks of the registers (control: bit 0 unused, bit 4 firmware only)
   localparam logic [7:0] MCOR_CTRL_WMASK  = 8'hEE;
   localparam logic [7:0] MCOR_IFSEL_WMASK = 8'hDB;
   localparam logic [7:0] MCOR_RATE_WMASK  = 8'h80;
   // Reset values
   localparam logic [7:0] MCOR_CTRL_RST    = 8'h00;
   localparam logic [7:0] MCOR_IFSEL_RST   = 8'h00;
   localparam logic [7:0] MCOR_RATE_RST    = 8'h00;
   // Interface type codes
   typedef enum logic [1:0] {
      MCOR_IF_SINGLE_ENDED,
      MCOR_IF_V35_TYPE,
      MCOR_IF_DIFF_TYPE,
      MCOR_IF_INTEGRAL_TYPE
   } mcor_iface_t;
endpackage : mcor_pkg

// ===== verif/mcor_modem.sv
// Modem model: ready some cycles after terminal ready, carrier while tone is on and modem ready
module mcor_modem (
   input  wire logic CLK, ARST_N, TERMINAL_READY, LOCAL_LOOP_REQ, REMOTE_LOOP_REQ, slow, tone,
   output logic      MODEM_READY, CARRIER_DETECT, test_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] up_reg;
   always_ff @(posedge CLK or negedge ARST_N)
      if (!ARST_N || !TERMINAL_READY) up_reg <= 5'h00;
      else if (up_reg != 5'h1F) up_reg <= up_reg + 5'h01;
   // nothing buffered, so drop at once
   assign MODEM_READY = TERMINAL_READY && up_reg >= (slow ? 5'h14 : 5'h02);
   assign CARRIER_DETECT = tone && MODEM_READY;
   assign test_mode = LOCAL_LOOP_REQ || REMOTE_LOOP_REQ;
endmodule : mcor_modem

// ===== verif/mcor_regs_assertions.sv
// Checker of the modem control output ports
module mcor_regs_chk (
   input wire logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, FW_HDX_WE, FW_HDX_VAL,
   input wire logic TX_ACTIVE, RX_ACTIVE, CARRIER_DETECT, MODEM_READY, RATE_SELECT,
   input wire logic STANDBY_SELECT, REMOTE_LOOP_REQ, LOCAL_LOOP_REQ, BAND_SELECT,
   input wire logic TERMINAL_READY, POLLING, REQ_TO_SEND, TX_LOAD_EN, RX_ENABLE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [1:0] IFACE_TYPE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hdx_reg;
   wire  wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // Firmware alone moves half duplex
   always_ff @(posedge CLK or negedge ARST_N)
      if (!ARST_N) hdx_reg <= 1'h0;
      else if (FW_HDX_WE) hdx_reg <= FW_HDX_VAL;
   ctrl_pins_a: assert property (wr && PADDR == 12'h000 |->
      {POLLING, TERMINAL_READY, BAND_SELECT, LOCAL_LOOP_REQ, REMOTE_LOOP_REQ, STANDBY_SELECT}
      == {PWDATA[7:5], PWDATA[3:1]}) else $error("control pins");
   rate_pin_a: assert property (wr && PADDR == 12'h008 |-> RATE_SELECT == PWDATA[7])
      else $error("rate pin");
   pins_held_a: assert property (!PREADY |-> $stable({STANDBY_SELECT, POLLING}))
      else $error("pin moved");
   rts_lock_a: assert property (REQ_TO_SEND |-> $past(MODEM_READY))
      else $error("rts early");
   hdx_tx_a: assert property (hdx_reg && !FW_HDX_WE && (RX_ACTIVE || CARRIER_DETECT) |=>
      !TX_LOAD_EN && !REQ_TO_SEND) else $error("tx not held");
   hdx_rx_a: assert property (hdx_reg && !FW_HDX_WE && TX_ACTIVE |=> !RX_ENABLE)
      else $error("rx not held");
   if_default_a: assert property (wr && PADDR == 12'h004 && !PWDATA[0] |->
      ##[1:2] IFACE_TYPE == 2'h0) else $error("iface default");
   if_prio_a: assert property (wr && PADDR == 12'h004 && PWDATA[0] && PWDATA[3] |->
      ##[1:2] IFACE_TYPE == 2'h3) else $error("iface priority");
endmodule : mcor_regs_chk

bind mcor_regs mcor_regs_chk u_chk (.*);

// ===== verif/test_modem_control_output_regs.sv
// Bench of the modem control output registers
module test_modem_control_output_regs;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [11:0] a; logic [7:0] d, r; logic [1:0] f;} mcor_row_t;
   logic CLK = 1'h0, ARST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, slow = 1'h0;
   logic FW_HDX_WE = 1'h0, FW_HDX_VAL = 1'h0, TX_DATA_PENDING = 1'h0, TX_ACTIVE = 1'h0;
   logic RX_ACTIVE = 1'h0, DIFF_SWITCH = 1'h1, tone = 1'h0, err, PREADY, PSLVERR, test_mode;
   logic MODEM_READY, CARRIER_DETECT, RATE_SELECT, STANDBY_SELECT, REMOTE_LOOP_REQ, POLLING;
   logic LOCAL_LOOP_REQ, BAND_SELECT, TERMINAL_READY, REQ_TO_SEND, TX_LOAD_EN, RX_ENABLE;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic [3:0]  PSTRB = 4'hF;
   logic [1:0]  IFACE_TYPE;
   logic [7:0]  ctl = 8'h00, rate = 8'h00;
   int          n_mismatch = 0, checked = 0;
   mcor_row_t   rows [11] = '{'{12'h0,8'hFF,8'hEE,2'h0}, '{12'h0,8'hAA,8'hAA,2'h0},
      '{12'h8,8'hFF,8'h80,2'h0}, '{12'h8,8'h00,8'h00,2'h0}, '{12'h4,8'h90,8'h90,2'h0},
      '{12'h4,8'h91,8'h91,2'h1}, '{12'h4,8'h81,8'h81,2'h2}, '{12'h4,8'h19,8'h19,2'h3},
      '{12'h4,8'h25,8'h01,2'h0}, '{12'h4,8'hC1,8'hC1,2'h2}, '{12'h0,8'h44,8'h44,2'h2}};
   mcor_regs u_dut (.*);
   mcor_modem u_modem (.*);
   task automatic chk(input logic [31:0] s, e, input string n);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'h1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'h1;
      do @(posedge CLK); while (PREADY !== 1'h1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask : apb
   task automatic w(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : w
   task automatic fw(input logic v);
      @(posedge CLK);
      FW_HDX_WE <= 1'h1;
      FW_HDX_VAL <= v;
      @(posedge CLK);
      FW_HDX_WE <= 1'h0;
   endtask : fw
   task automatic wrap_up;
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial forever #5 CLK = ~CLK;
   initial begin
      repeat (3000) @(posedge CLK);
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge CLK);
      ARST_N <= 1'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1'h0, 12'(4 * i), 32'h0);
         chk(rd, (i == 3) ? 32'h4 : 32'h0, "reset");
      end
      foreach (rows[i]) begin
         apb(1'h1, rows[i].a, {24'h0, rows[i].d});
         apb(1'h0, rows[i].a, 32'h0);
         chk(rd, {24'h0, rows[i].r}, "readback");
         if (rows[i].a == 12'h0) ctl = rows[i].r;
         if (rows[i].a == 12'h8) rate = rows[i].r;
         w(1);
         chk({POLLING, TERMINAL_READY, BAND_SELECT, 1'h0, LOCAL_LOOP_REQ, REMOTE_LOOP_REQ,
            STANDBY_SELECT, 1'h0}, ctl, "pins");
         chk(RATE_SELECT, rate[7], "rate");
         chk(test_mode, ctl[3] | ctl[2], "test mode");
         chk(IFACE_TYPE, rows[i].f, "iface");
      end
      @(posedge CLK) DIFF_SWITCH <= 1'h0;
      w(2);
      chk(IFACE_TYPE, 2'h0, "no switch");
      apb(1'h1, 12'h010, 32'hFF);
      chk(err, 1'h1, "unmapped");
      apb(1'h1, 12'h0, 32'h0);
      @(posedge CLK) PSTRB <= 4'hE;
      apb(1'h1, 12'h0, 32'hFF);
      @(posedge CLK) PSTRB <= 4'hF;
      apb(1'h0, 12'h0, 32'h0);
      chk(rd, 32'h0, "no strobe");
      @(posedge CLK) TX_DATA_PENDING <= 1'h1;
      slow <= 1'h1;
      apb(1'h1, 12'h0, 32'h40);
      w(8);
      chk(REQ_TO_SEND, 1'h0, "rts locked");
      w(20);
      chk(REQ_TO_SEND, 1'h1, "rts");
      fw(1'h1);
      apb(1'h1, 12'h0, 32'h40);
      apb(1'h0, 12'h0, 32'h0);
      chk(rd, 32'h50, "hdx bit");
      @(posedge CLK) tone <= 1'h1;
      w(3);
      chk({TX_LOAD_EN, REQ_TO_SEND}, 2'h0, "carrier");
      @(posedge CLK) tone <= 1'h0;
      RX_ACTIVE <= 1'h1;
      w(3);
      chk(TX_LOAD_EN, 1'h0, "rx busy");
      @(posedge CLK) RX_ACTIVE <= 1'h0;
      TX_ACTIVE <= 1'h1;
      w(3);
      chk({TX_LOAD_EN, RX_ENABLE}, 2'h2, "tx busy");
      fw(1'h0);
      w(2);
      chk(RX_ENABLE, 1'h1, "full duplex");
      wrap_up;
   end
endmodule : test_modem_control_output_regs
